// file: dv/rsci_asserts.sv
// Purpose: port-level checks for rsci_top
// Assumes: hs_ignore is set with dtr low for less than one frame only
// Notes: every bit lasts at least 8 cycles, as CLK_HZ/9600 >= 8
`timescale 1ns/10ps
module rsci_asserts #(
  parameter int unsigned CLK_HZ = rsci_pkg::CLK_HZ_DEF
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic rxd,
  input wire logic txd,
  input wire logic dtr,
  input wire logic cts,
  input wire logic [6:0] rear_config_switches
);
  // a frame already in flight may still finish after dtr drops
  localparam logic [31:0] FRAME_MAX = 32'(12 * (CLK_HZ / 300) + 4);
  logic [31:0] dtr_low_reg;
  logic rd_take;
  logic tx_take;
  assign rd_take = hsel && htrans[1] && hready && !hwrite;
  assign tx_take = hsel && htrans[1] && hready && hwrite
    && haddr[7:0] inside {8'h04, 8'h08, 8'h0C};
  // cycles spent with dtr low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dtr_low_reg <= 32'h0;
    end else begin
      dtr_low_reg <= dtr ? 32'h0 : dtr_low_reg + 32'h1;
    end
  end
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("hresp not OKAY");
  a_read_nowait: assert property (rd_take |=> hreadyout)
    else $error("read was stalled");
  a_tx_wait: assert property (tx_take |=> !hreadyout)
    else $error("tx write not stalled");
  a_config_read: assert property (rd_take && haddr[7:0] == 8'h18 |=>
    hrdata == {25'h0, $past(rear_config_switches)}) else $error("config read wrong");
  a_cts_ready: assert property ($rose(hresetn) |=> cts)
    else $error("cts not up after reset");
  a_txd_idle: assert property ($rose(hresetn) |-> txd)
    else $error("txd not idle");
  a_bit_low: assert property ($fell(txd) |-> !txd [*8])
    else $error("short low bit");
  a_bit_high: assert property ($rose(txd) |-> txd [*8])
    else $error("short high bit");
  a_dtr_hold: assert property (dtr_low_reg > FRAME_MAX |-> txd)
    else $error("sent while dtr low");
  a_cts_stop: assert property ($fell(cts) |-> rxd && $past(rxd))
    else $error("cts fell outside stop bit");
endmodule : rsci_asserts

bind rsci_top rsci_asserts #(.CLK_HZ(CLK_HZ)) i_rsci_asserts (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hrdata(hrdata), .hresp(hresp), .rxd(rxd), .txd(txd), .dtr(dtr), .cts(cts),
  .rear_config_switches(rear_config_switches));

// file: dv/rsci_host.sv
// Purpose: host computer on the far side of the serial link
// Assumes: bench sets the format fields before each transfer
// Notes: ignores cts, so it can overrun the device on purpose
`timescale 1ns/10ps
module rsci_host (
  input wire logic hclk,
  input wire logic txd,
  output logic rxd,
  output logic dtr
);
  int bit_cyc = 10;
  logic eight = 1'b1;
  logic par_en = 1'b0;
  logic par_odd = 1'b0;
  logic [7:0] got_q[$];
  logic [7:0] c;
  int perr = 0;
  // idle line high, permit on
  initial begin
    rxd = 1'b1;
    dtr = 1'b1;
  end
  // one frame: start, data lsb first, optional parity, stop
  task automatic send(input logic [7:0] ch, input logic bad);
    rxd <= 1'b0;
    repeat (bit_cyc) @(posedge hclk);
    for (int i = 0; i < (eight ? 8 : 7); i++) begin
      rxd <= ch[i];
      repeat (bit_cyc) @(posedge hclk);
    end
    if (par_en) begin
      rxd <= (eight ? ^ch : ^ch[6:0]) ^ par_odd ^ bad;
      repeat (bit_cyc) @(posedge hclk);
    end
    rxd <= 1'b1;
    repeat (bit_cyc) @(posedge hclk);
  endtask : send
  // receive at mid-bit; bad parity or stop counts as error
  always begin
    @(negedge txd);
    repeat (bit_cyc / 2) @(posedge hclk);
    c = 8'h00;
    for (int i = 0; i < (eight ? 8 : 7); i++) begin
      repeat (bit_cyc) @(posedge hclk);
      c[i] = txd;
    end
    if (par_en) begin
      repeat (bit_cyc) @(posedge hclk);
      if (txd !== ((eight ? ^c : ^c[6:0]) ^ par_odd)) perr++;
    end
    repeat (bit_cyc) @(posedge hclk);
    if (txd !== 1'b1) perr++;
    got_q.push_back(c);
  end
endmodule : rsci_host

// file: dv/testbench.sv
// Purpose: directed test of rsci_top over AHB-Lite and serial link
// Assumes: small DEPTH and CLK_HZ keep the run short
// Notes: bus waits rely on the watchdog to end a hang
`timescale 1ns/10ps
module testbench;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [6:0] sw = 7'h58;
  logic hreadyout, hresp, rxd, txd, dtr, cts;
  logic [31:0] hrdata;
  int bad_count = 0;
  int tests_run = 0;
  logic [31:0] pops[21] = '{32'h446, 32'h452, 32'h445, 32'h451, 32'h103F, 32'h23B,
    32'h44E, 32'h441, 32'h456, 32'h447, 32'h33, 32'h82C, 32'h34, 32'h30A, 32'h8000_0000,
    32'h454, 32'h452, 32'h449, 32'h447, 32'h30D, 32'h8000_0000};
  string tx_s = "5;9\r\n1\n";
  rsci_top #(.CLK_HZ(96000), .DEPTH(16)) i_rsci_top (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .rxd(rxd), .txd(txd),
    .dtr(dtr), .cts(cts), .rear_config_switches(sw));
  rsci_host i_rsci_host (.hclk(hclk), .txd(txd), .rxd(rxd), .dtr(dtr));
  // 50 MHz
  always #10 hclk = ~hclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // single word: address phase until hready, then data phase until hready
  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] wd,
    output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    bus(a, 1'b0, 32'h0, d);
    chk(d, exp);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] d;
    bus(a, 1'b1, v, d);
  endtask : wr
  task automatic sends(input string s);
    for (int i = 0; i < s.len(); i++) i_rsci_host.send(s[i], 1'b0);
  endtask : sends
  task automatic got(input int n, input logic [7:0] exp);
    while (i_rsci_host.got_q.size() < n) @(posedge hclk);
    chk({24'h0, i_rsci_host.got_q.pop_front()}, {24'h0, exp});
  endtask : got
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // watchdog well past the expected run length
  initial begin
    #(20 * 100000);
    bad_count++;
    tally_and_finish();
  end
  // main sequence
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(8'h10, 32'h2000_0000);
    rd(8'h18, 32'h58);
    rd(8'h1C, 32'h0);
    sends("fR eq?");
    rd(8'h00, 32'h8000_0000);
    sends(";nAvg 3,4\n");
    foreach (pops[k]) begin
      if (k == 15) sends("tRig\r\n");
      rd(8'h00, pops[k]);
    end
    // replies: digits, separator, text end, binary end
    wr(8'h0C, 32'h5);
    wr(8'h08, 32'h2);
    wr(8'h0C, 32'h9);
    wr(8'h08, 32'h0);
    wr(8'h0C, 32'h1);
    wr(8'h08, 32'h1);
    for (int k = 0; k < 7; k++) got(1, tx_s[k]);
    // held by dtr, long enough to pass a whole frame
    i_rsci_host.dtr <= 1'b0;
    wr(8'h04, 32'h5A);
    repeat (4000) @(posedge hclk);
    chk(i_rsci_host.got_q.size(), 0);
    i_rsci_host.dtr <= 1'b1;
    got(1, 8'h5A);
    // three-wire use ignores dtr; a flush drops a half line
    i_rsci_host.dtr <= 1'b0;
    wr(8'h14, 32'h1);
    wr(8'h04, 32'h4E);
    got(1, 8'h4E);
    rd(8'h14, 32'h1);
    sends("zz");
    i_rsci_host.dtr <= 1'b1;
    rd(8'h10, 32'h2000_0002);
    wr(8'h14, 32'h2);
    rd(8'h10, 32'h2000_0000);
    // fill, drain one, refill, overrun
    sends("abcdefghijklmno\n");
    chk(cts, 1'b0);
    rd(8'h00, 32'h441);
    @(posedge hclk);
    chk(cts, 1'b1);
    sends("pq");
    rd(8'h10, 32'h2100_0000);
    rd(8'h00, 32'h8000_0000);
    wr(8'h10, 32'h0100_0000);
    // every baud step, 7 and 8 bits, parity off, even, odd
    for (int s = 0; s < 6; s++) begin
      sw <= {s[2:0], ~s[0], s[0], s > 1, 1'b0};
      i_rsci_host.bit_cyc = 96000 / (300 << s);
      i_rsci_host.eight = ~s[0];
      i_rsci_host.par_odd = s[0];
      i_rsci_host.par_en = s > 1;
      @(posedge hclk);
      wr(8'h0C, s);
      got(1, 8'h30 + 8'(s));
      sends("k\n");
      rd(8'h00, 32'h44B);
      rd(8'h00, 32'h30A);
      // a one-letter command is flagged as a short mnemonic
      rd(8'h10, 32'h2800_0000);
      wr(8'h10, 32'h0800_0000);
    end
    chk(i_rsci_host.perr, 0);
    i_rsci_host.send(8'h4B, 1'b1);
    sends("\n");
    rd(8'h00, 32'h44B);
    rd(8'h00, 32'h30A);
    rd(8'h10, 32'h2A00_0000);
    wr(8'h10, 32'h0200_0000);
    rd(8'h10, 32'h2800_0000);
    tally_and_finish();
  end
endmodule : testbench

// file: logic/rsci_pkg.sv
// Purpose: shared constants for the serial command front end
// Assumes: 32-bit AHB-Lite register window, one word per register
// Notes: bit timing is derived from the clock rate by bit_cycles
package rsci_pkg;
  localparam int unsigned CLK_HZ_DEF = 50000000;
  localparam int unsigned BASE_BAUD = 300;
  localparam int unsigned BUF_DEPTH = 256;
  // register byte offsets
  localparam logic [7:0] A_RXDATA = 8'h00;
  localparam logic [7:0] A_TXDATA = 8'h04;
  localparam logic [7:0] A_TXEND = 8'h08;
  localparam logic [7:0] A_TXDIG = 8'h0C;
  localparam logic [7:0] A_STATUS = 8'h10;
  localparam logic [7:0] A_CTRL = 8'h14;
  localparam logic [7:0] A_CONFIG = 8'h18;
  // field positions
  localparam int E_EOL = 8;
  localparam int RX_EMPTY = 31;
  localparam int ST_LINES = 9;
  localparam int ST_OVF = 24;
  localparam int ST_PERR = 25;
  localparam int ST_FERR = 26;
  localparam int ST_CERR = 27;
  localparam int ST_TXB = 28;
  localparam int ST_CTS = 29;
  localparam int SW_PAR = 1;
  localparam int SW_ODD = 2;
  localparam int SW_EIGHT = 3;
  localparam int SW_BAUD = 4;
  // characters
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_SEMI = 8'h3B;
  localparam logic [7:0] CH_COMMA = 8'h2C;
  localparam logic [7:0] CH_QM = 8'h3F;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_LA = 8'h61;
  localparam logic [7:0] CH_LZ = 8'h7A;
  localparam logic [7:0] CASE_OFS = 8'h20;
  localparam logic [2:0] MNEM_LEN = 3'h4;

  // cycles per bit; selections above 5 stay at the fastest rate
  function automatic logic [17:0] bit_cycles(int unsigned clk_hz, logic [2:0] sel);
    int unsigned s;
    s = (sel > 3'h5) ? 5 : int'(sel);
    return 18'(clk_hz / (BASE_BAUD << s));
  endfunction : bit_cycles
endpackage : rsci_pkg

// file: logic/rsci_rx.sv
// Purpose: serial character receiver
// Assumes: rxd already synchronous to hclk
// Notes: samples each bit once at its middle
`timescale 1ns/10ps
module rsci_rx (
  input wire logic hclk,
  input wire logic hresetn,
  rsci_ser_if.rx sif,
  input wire logic rxd
);
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} rsci_rx_st_t;
  rsci_rx_st_t st_reg;
  logic [17:0] tmr_reg;
  logic [3:0] idx_reg;
  logic [8:0] sh_reg;
  logic [3:0] last;
  logic [7:0] dat;
  logic pbit;
  // index of the final data or parity bit
  assign last = (sif.eight ? 4'h8 : 4'h7) - (sif.par_en ? 4'h0 : 4'h1);
  assign dat = sif.eight ? sh_reg[7:0] : {1'b0, sh_reg[6:0]};
  assign pbit = sif.eight ? sh_reg[8] : sh_reg[7];
  // start, data, optional parity, one stop bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= RX_IDLE;
      tmr_reg <= '0;
      idx_reg <= '0;
      sh_reg <= '0;
      sif.rx_valid <= 1'b0;
      sif.rx_data <= '0;
      sif.rx_perr <= 1'b0;
      sif.rx_ferr <= 1'b0;
    end else begin
      sif.rx_valid <= 1'b0;
      if (tmr_reg != 18'h0) tmr_reg <= tmr_reg - 18'h1;
      unique case (st_reg)
        RX_IDLE: if (!rxd) begin
          tmr_reg <= {1'b0, sif.bit_cyc[17:1]};
          st_reg <= RX_START;
        end
        RX_START: if (tmr_reg == 18'h0) begin
          // a start bit gone high at its middle was a glitch
          st_reg <= rxd ? RX_IDLE : RX_BITS;
          tmr_reg <= sif.bit_cyc - 18'h1;
          idx_reg <= '0;
        end
        RX_BITS: if (tmr_reg == 18'h0) begin
          sh_reg[idx_reg] <= rxd;
          idx_reg <= idx_reg + 4'h1;
          tmr_reg <= sif.bit_cyc - 18'h1;
          if (idx_reg == last) st_reg <= RX_STOP;
        end
        RX_STOP: if (tmr_reg == 18'h0) begin
          sif.rx_valid <= 1'b1;
          sif.rx_data <= dat;
          sif.rx_perr <= sif.par_en && ((^dat ^ pbit) != sif.par_odd);
          sif.rx_ferr <= !rxd;
          st_reg <= RX_IDLE;
        end
      endcase
    end
  end
endmodule : rsci_rx

// file: logic/rsci_ser_if.sv
// Purpose: bundle between the controller and the serial bit engines
// Assumes: one clock domain
// Notes: format fields are steady except when the switches move
`timescale 1ns/10ps
interface rsci_ser_if;
  logic [17:0] bit_cyc;
  logic par_en;
  logic par_odd;
  logic eight;
  logic rx_valid;
  logic [7:0] rx_data;
  logic rx_perr;
  logic rx_ferr;
  logic tx_start;
  logic [7:0] tx_data;
  logic tx_busy;
  modport ctl(output bit_cyc, par_en, par_odd, eight, tx_start, tx_data,
    input rx_valid, rx_data, rx_perr, rx_ferr, tx_busy);
  modport rx(input bit_cyc, par_en, par_odd, eight,
    output rx_valid, rx_data, rx_perr, rx_ferr);
  modport tx(input bit_cyc, par_en, par_odd, eight, tx_start, tx_data,
    output tx_busy);
endinterface : rsci_ser_if

// file: logic/rsci_top.sv
// Purpose: serial command front end, registers on AHB-Lite
// Assumes: all inputs synchronous to hclk; bus master issues single words
// Notes: software parses lines popped from the buffer; only haddr[7:0] decoded
//
// The register offsets and the AHB-Lite register port were decided locally.
`timescale 1ns/10ps
module rsci_top #(
  parameter int unsigned CLK_HZ = rsci_pkg::CLK_HZ_DEF,
  parameter int unsigned DEPTH = rsci_pkg::BUF_DEPTH
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic rxd,
  output logic txd,
  input wire logic dtr,
  output logic cts,
  input wire logic [6:0] rear_config_switches
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned CW = AW + 1;

  if (DEPTH < 4 || DEPTH > 256 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("rsci_top: DEPTH must be a power of two from 4 to 256");
  end
  if (CLK_HZ / 9600 < 8 || CLK_HZ / 300 > 262143) begin : g_bad_clk
    $error("rsci_top: CLK_HZ outside the range of the bit timers");
  end

  // tx-bound registers stall the bus until the send queue is free
  function automatic logic is_tx_addr(logic [7:0] a);
    return a == rsci_pkg::A_TXDATA || a == rsci_pkg::A_TXEND || a == rsci_pkg::A_TXDIG;
  endfunction : is_tx_addr

  rsci_ser_if sif ();

  rsci_rx u_rx (
    .hclk(hclk),
    .hresetn(hresetn),
    .sif(sif),
    .rxd(rxd)
  );

  rsci_tx u_tx (
    .hclk(hclk),
    .hresetn(hresetn),
    .sif(sif),
    .txd(txd)
  );

  // serial format
  logic [17:0] bit_cyc_reg;
  logic par_en_reg;
  logic par_odd_reg;
  logic eight_reg;
  // bus slave
  logic acc;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic wr_do;
  logic hreadyout_reg;
  logic [31:0] hrdata_reg;
  logic [31:0] rd_word;
  logic [31:0] status;
  // receive path
  logic [7:0] rx_up;
  logic is_term;
  logic is_semi;
  logic is_comma;
  logic is_query;
  logic is_space;
  logic plain;
  logic cend;
  logic mnem;
  logic drop;
  logic push;
  logic pop;
  logic full;
  logic ovf_evt;
  logic flush;
  logic [12:0] entry;
  logic [12:0] head;
  logic [12:0] buf_mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] lines_reg;
  logic line_open_reg;
  logic [2:0] mn_cnt_reg;
  // flags and control
  logic ovf_reg;
  logic perr_reg;
  logic ferr_reg;
  logic cerr_reg;
  logic [31:0] st_clr;
  logic hs_ignore_reg;
  logic cts_reg;
  // transmit path
  logic tx_q_valid_reg;
  logic [7:0] tx_q_reg;
  logic pend_lf_reg;
  logic tx_start_reg;
  logic [7:0] tx_data_reg;
  logic tx_go;
  logic tx_q_ok;

  // format tracks the switches; a change mid-character spoils that one, and later ones if last drops below idx_reg, as rsci_rx samples on until it wraps
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bit_cyc_reg <= rsci_pkg::bit_cycles(CLK_HZ, 3'h0);
      par_en_reg <= 1'b0;
      par_odd_reg <= 1'b0;
      eight_reg <= 1'b1;
    end else begin
      bit_cyc_reg <= rsci_pkg::bit_cycles(CLK_HZ,
        rear_config_switches[rsci_pkg::SW_BAUD +: 3]);
      par_en_reg <= rear_config_switches[rsci_pkg::SW_PAR];
      par_odd_reg <= rear_config_switches[rsci_pkg::SW_ODD];
      eight_reg <= rear_config_switches[rsci_pkg::SW_EIGHT];
    end
  end

  assign sif.bit_cyc = bit_cyc_reg;
  assign sif.par_en = par_en_reg;
  assign sif.par_odd = par_odd_reg;
  assign sif.eight = eight_reg;
  assign sif.tx_start = tx_start_reg;
  assign sif.tx_data = tx_data_reg;

  // case folding of received letters
  always_comb begin
    rx_up = sif.rx_data;
    if (sif.rx_data >= rsci_pkg::CH_LA && sif.rx_data <= rsci_pkg::CH_LZ) begin
      rx_up = sif.rx_data - rsci_pkg::CASE_OFS;
    end
  end

  // character classes
  assign is_term = rx_up == rsci_pkg::CH_CR || rx_up == rsci_pkg::CH_LF;
  assign is_semi = rx_up == rsci_pkg::CH_SEMI;
  assign is_comma = rx_up == rsci_pkg::CH_COMMA;
  assign is_query = rx_up == rsci_pkg::CH_QM;
  assign is_space = rx_up == rsci_pkg::CH_SP;
  assign plain = !(is_term || is_semi || is_comma || is_query || is_space);
  assign cend = is_semi || is_term;
  assign mnem = plain && mn_cnt_reg < rsci_pkg::MNEM_LEN;
  // second half of a CR LF pair would make an empty line, so it is dropped
  assign drop = is_space || (is_term && !line_open_reg);
  assign push = sif.rx_valid && !drop;
  assign full = cnt_reg == CW'(DEPTH);
  assign ovf_evt = push && full;
  // flags: query, separator, mnemonic char, command end, line end
  assign entry = {is_query, is_comma, mnem, cend, is_term, rx_up};
  assign head = buf_mem[rd_ptr_reg];
  // only terminated lines may be popped
  assign pop = acc && !hwrite && haddr[7:0] == rsci_pkg::A_RXDATA
    && lines_reg != '0;
  assign flush = wr_do && wr_addr_reg == rsci_pkg::A_CTRL && hwdata[1];

  // buffer pointers and line bookkeeping, first in first out
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg <= '0;
      lines_reg <= '0;
      line_open_reg <= 1'b0;
      mn_cnt_reg <= '0;
    end else if (ovf_evt || flush) begin
      // whole contents discarded, pending lines too
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg <= '0;
      lines_reg <= '0;
      line_open_reg <= 1'b0;
      mn_cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
        line_open_reg <= !is_term;
        if (cend) mn_cnt_reg <= '0;
        else if (mnem) mn_cnt_reg <= mn_cnt_reg + 3'h1;
      end
      if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
      cnt_reg <= cnt_reg + CW'(push) - CW'(pop);
      lines_reg <= lines_reg + CW'(push && is_term)
        - CW'(pop && head[rsci_pkg::E_EOL]);
    end
  end

  // storage needs no reset; pointers say what is valid
  always_ff @(posedge hclk) begin
    if (push && !full) buf_mem[wr_ptr_reg] <= entry;
  end

  // sticky error flags; a new event beats a clear in the same cycle
  assign st_clr = (wr_do && wr_addr_reg == rsci_pkg::A_STATUS) ? hwdata : 32'h0;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ovf_reg <= 1'b0;
      perr_reg <= 1'b0;
      ferr_reg <= 1'b0;
      cerr_reg <= 1'b0;
    end else begin
      ovf_reg <= ovf_evt || (ovf_reg && !st_clr[rsci_pkg::ST_OVF]);
      perr_reg <= (sif.rx_valid && sif.rx_perr)
        || (perr_reg && !st_clr[rsci_pkg::ST_PERR]);
      ferr_reg <= (sif.rx_valid && sif.rx_ferr)
        || (ferr_reg && !st_clr[rsci_pkg::ST_FERR]);
      // a short mnemonic ended by query, comma or command end
      cerr_reg <= (push && (is_query || is_comma || cend) && mn_cnt_reg != 3'h0
        && mn_cnt_reg < rsci_pkg::MNEM_LEN)
        || (cerr_reg && !st_clr[rsci_pkg::ST_CERR]);
    end
  end

  // control bit and ready handshake
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hs_ignore_reg <= 1'b0;
      cts_reg <= 1'b0;
    end else begin
      if (wr_do && wr_addr_reg == rsci_pkg::A_CTRL) hs_ignore_reg <= hwdata[0];
      // one cycle behind the count; drops only once full, so a host mid-character overruns
      cts_reg <= !full;
    end
  end

  // read mux, sampled at the address phase
  always_comb begin
    status = 32'h0;
    status[8:0] = 9'(cnt_reg);
    status[rsci_pkg::ST_LINES +: 9] = 9'(lines_reg);
    status[rsci_pkg::ST_OVF] = ovf_reg;
    status[rsci_pkg::ST_PERR] = perr_reg;
    status[rsci_pkg::ST_FERR] = ferr_reg;
    status[rsci_pkg::ST_CERR] = cerr_reg;
    status[rsci_pkg::ST_TXB] = sif.tx_busy || tx_q_valid_reg || pend_lf_reg || tx_start_reg;
    status[rsci_pkg::ST_CTS] = cts_reg;
    rd_word = 32'h0;
    if (haddr[7:0] == rsci_pkg::A_RXDATA) begin
      if (lines_reg != '0) rd_word = {19'h0, head};
      else rd_word[rsci_pkg::RX_EMPTY] = 1'b1;
    end else if (haddr[7:0] == rsci_pkg::A_STATUS) begin
      rd_word = status;
    end else if (haddr[7:0] == rsci_pkg::A_CTRL) begin
      rd_word = {31'h0, hs_ignore_reg};
    end else if (haddr[7:0] == rsci_pkg::A_CONFIG) begin
      rd_word = {25'h0, rear_config_switches};
    end
  end

  // bus slave: reads answer with no wait; tx writes wait for the queue
  assign acc = hsel && htrans[1] && hready;
  assign tx_q_ok = !tx_q_valid_reg && !pend_lf_reg;
  assign wr_do = wr_pend_reg && (!is_tx_addr(wr_addr_reg) || tx_q_ok);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
      hreadyout_reg <= 1'b1;
      hrdata_reg <= '0;
    end else begin
      if (wr_do) begin
        wr_pend_reg <= 1'b0;
        hreadyout_reg <= 1'b1;
      end
      if (acc) begin
        wr_pend_reg <= hwrite;
        wr_addr_reg <= haddr[7:0];
        hreadyout_reg <= !(hwrite && is_tx_addr(haddr[7:0]));
        if (!hwrite) hrdata_reg <= rd_word;
      end
    end
  end

  assign hreadyout = hreadyout_reg;
  assign hrdata = hrdata_reg;
  assign hresp = 1'b0;
  assign cts = cts_reg;

  // send only while the host permits, unless handshake is off
  assign tx_go = !tx_start_reg && !sif.tx_busy && (tx_q_valid_reg || pend_lf_reg)
    && (dtr || hs_ignore_reg);

  // one-character send queue plus a pending line feed
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_q_valid_reg <= 1'b0;
      tx_q_reg <= '0;
      pend_lf_reg <= 1'b0;
      tx_start_reg <= 1'b0;
      tx_data_reg <= '0;
    end else begin
      tx_start_reg <= 1'b0;
      if (wr_do && is_tx_addr(wr_addr_reg)) begin
        tx_q_valid_reg <= 1'b1;
        if (wr_addr_reg == rsci_pkg::A_TXDATA) begin
          tx_q_reg <= hwdata[7:0];
        end else if (wr_addr_reg == rsci_pkg::A_TXDIG) begin
          // decimal digit of an integer answer; values 10 to 15 are not blocked
          tx_q_reg <= rsci_pkg::CH_ZERO + {4'h0, hwdata[3:0]};
        end else if (hwdata[0]) begin
          tx_q_reg <= rsci_pkg::CH_LF;
        end else if (hwdata[1]) begin
          tx_q_reg <= rsci_pkg::CH_SEMI;
        end else begin
          tx_q_reg <= rsci_pkg::CH_CR;
          pend_lf_reg <= 1'b1;
        end
      end
      if (tx_go) begin
        tx_start_reg <= 1'b1;
        if (tx_q_valid_reg) begin
          tx_data_reg <= tx_q_reg;
          tx_q_valid_reg <= 1'b0;
        end else begin
          tx_data_reg <= rsci_pkg::CH_LF;
          pend_lf_reg <= 1'b0;
        end
      end
    end
  end
endmodule : rsci_top

// file: logic/rsci_tx.sv
// Purpose: serial character transmitter
// Assumes: tx_start is a one-cycle pulse seen only while idle
// Notes: txd idles high
`timescale 1ns/10ps
module rsci_tx (
  input wire logic hclk,
  input wire logic hresetn,
  rsci_ser_if.tx sif,
  output logic txd
);
  typedef enum logic {TX_IDLE, TX_SEND} rsci_tx_st_t;
  rsci_tx_st_t st_reg;
  logic [17:0] tmr_reg;
  logic [3:0] left_reg;
  logic [10:0] sh_reg;
  logic [10:0] frame;
  logic pd;
  // data bits, optional parity, stop bit; upper bits stay high
  always_comb begin
    frame = 11'h7FF;
    frame[6:0] = sif.tx_data[6:0];
    pd = ^sif.tx_data[6:0];
    if (sif.eight) begin
      frame[7] = sif.tx_data[7];
      pd = ^sif.tx_data;
    end
    if (sif.par_en) frame[sif.eight ? 8 : 7] = pd ^ sif.par_odd;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= TX_IDLE;
      tmr_reg <= '0;
      left_reg <= '0;
      sh_reg <= '0;
      txd <= 1'b1;
      sif.tx_busy <= 1'b0;
    end else begin
      unique case (st_reg)
        TX_IDLE: if (sif.tx_start) begin
          txd <= 1'b0;
          sh_reg <= frame;
          left_reg <= (sif.eight ? 4'h9 : 4'h8) + (sif.par_en ? 4'h1 : 4'h0);
          tmr_reg <= sif.bit_cyc - 18'h1;
          sif.tx_busy <= 1'b1;
          st_reg <= TX_SEND;
        end
        TX_SEND: if (tmr_reg != 18'h0) begin
          tmr_reg <= tmr_reg - 18'h1;
        end else if (left_reg == 4'h0) begin
          txd <= 1'b1;
          sif.tx_busy <= 1'b0;
          st_reg <= TX_IDLE;
        end else begin
          txd <= sh_reg[0];
          sh_reg <= sh_reg >> 1;
          left_reg <= left_reg - 4'h1;
          tmr_reg <= sif.bit_cyc - 18'h1;
        end
      endcase
    end
  end
endmodule : rsci_tx
